// ===== rtl/tc_pkg.sv
package tc_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0]  OFS_CTRLA       = 8'h00;
   localparam logic [7:0]  OFS_CTRLB       = 8'h04;
   localparam logic [7:0]  OFS_EVCTRL      = 8'h08;
   localparam logic [7:0]  OFS_INTEN       = 8'h0c;
   localparam logic [7:0]  OFS_INTFLAG     = 8'h10;
   localparam logic [7:0]  OFS_STATUS      = 8'h14;
   localparam logic [7:0]  OFS_COUNT       = 8'h18;
   localparam logic [7:0]  OFS_PERIOD      = 8'h1c;
   localparam logic [7:0]  OFS_CC0         = 8'h20;
   localparam logic [7:0]  OFS_CC1         = 8'h24;
   localparam logic [7:0]  OFS_CTRLC       = 8'h28;
   localparam logic [7:0]  OFS_PART_STATUS = 8'h2c;
   localparam logic [7:0]  OFS_PART_COUNT  = 8'h30;
   // Field positions
   localparam int          CTRLA_WIDTH_LSB = 0;
   localparam int          CTRLA_WAVE_LSB  = 2;
   localparam int          CTRLA_ENABLE    = 4;
   localparam int          COUNT_DIRECTION_BIT       = 0;
   localparam int          CTRLB_ONESHOT   = 1;
   localparam int          CTRLB_CMD_LSB   = 4;
   localparam int          OVERFLOW_EVENT_OUT_ENABLE    = 8;
   localparam int          EVCTRL_MCEO_LSB = 12;
   localparam int          FLAG_OVF        = 0;
   localparam int          FLAG_MC_LSB     = 4;
   localparam int          STATUS_STOP     = 0;
   localparam int          STATUS_SLAVE    = 1;
   localparam int          NUM_CH          = 2;
   // Counter widths (counter_width_select)
   localparam logic [1:0]  WIDTH_SIXTEEN    = 2'h0;
   localparam logic [1:0]  WIDTH_EIGHT      = 2'h1;
   localparam logic [1:0]  WIDTH_THIRTYTWO  = 2'h2;
   // Waveform modes (waveform_mode_select)
   localparam logic [1:0]  PLAIN_TOGGLE_MODE       = 2'h0;
   localparam logic [1:0]  CHANNEL_TOP_TOGGLE_MODE = 2'h1;
   localparam logic [1:0]  SINGLE_SLOPE_PULSE_MODE = 2'h2;
   localparam logic [1:0]  CHANNEL_TOP_PULSE_MODE  = 2'h3;
   // Event actions (event_action_select)
   localparam logic [2:0]  EVACT_OFF       = 3'h0;
   localparam logic [2:0]  RESTART_ACTION  = 3'h1;
   localparam logic [2:0]  EVACT_COUNT     = 3'h2;
   localparam logic [2:0]  EVACT_START     = 3'h3;
   // Commands (command_field)
   localparam logic [1:0]  CMD_NONE        = 2'h0;
   localparam logic [1:0]  CMD_RESTART_ACTION   = 2'h1;
   localparam logic [1:0]  CMD_STOP        = 2'h2;
   // Reset values and maxima
   localparam logic [31:0] MAX8            = 32'h000000ff;
   localparam logic [31:0] MAX16           = 32'h0000ffff;
   localparam logic [31:0] MAX32           = 32'hffffffff;
   localparam logic [7:0]  PERIOD_RESET    = 8'hff;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   // Counter states
   typedef enum logic [3:0] {
      ST_OFF   = 4'b0001,
      ST_ARMED = 4'b0010,
      ST_RUN   = 4'b0100,
      ST_HALT  = 4'b1000
   } cnt_state_t;
endpackage

// ===== rtl/event_timer_counter_compare.sv
`timescale 1ns/1ps
`default_nettype none
module event_timer_counter_compare
   import tc_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // AXI4-Lite write address and data
   input  wire logic [7:0]        awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // AXI4-Lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [7:0]        araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Tick sources and event input
   input  wire logic              gclk_tick,
   input  wire logic              event_in,
   // Events, interrupt and waveforms
   output logic                   ovf_event,
   output logic [NUM_CH-1:0]      match_event,
   output logic                   irq,
   output logic [NUM_CH-1:0]      waveform_out
);
   // Software registers
   logic [1:0]        width_reg;        // counter_width_select
   logic [1:0]        wave_reg;         // waveform_mode_select
   logic              enable_reg;       // Unit enable
   logic              dir_reg;          // count_direction_bit
   logic              oneshot_reg;      // One-shot select
   logic [1:0]        cmd_reg;          // command_field, pending one cycle
   logic [2:0]        evact_reg;        // event_action_select
   logic              ovfeo_reg;        // overflow_event_out_enable
   logic [NUM_CH-1:0] mceo_reg;         // channel_match_event_enable
   logic              ovf_ie_reg;       // Overflow interrupt enable
   logic [NUM_CH-1:0] mc_ie_reg;        // channel_match_irq_enable
   logic              ovf_flag_reg;     // overflow_flag
   logic [NUM_CH-1:0] mc_flag_reg;      // channel_match_flag
   logic [31:0]       count_reg;        // Counter value
   logic [7:0]        period_reg;       // period_value
   logic [31:0]       cc_reg [NUM_CH];  // channel_compare_value
   logic [NUM_CH-1:0] inv_reg;          // output_invert_bit
   logic [31:0]       part_count_reg;   // Odd partner count register
   logic [NUM_CH-1:0] wave_out_reg;     // Raw waveform state
   logic              fresh_reg;        // Count untouched since disable
   cnt_state_t        state_reg;        // Counter state
   cnt_state_t        state_next;
   logic [31:0]       count_next;
   // Bus handshake state
   logic              bvalid_reg;
   logic              rvalid_reg;
   logic [1:0]        bresp_reg;
   logic [1:0]        rresp_reg;
   logic [31:0]       rdata_reg;
   // Write channel decode: address and data taken together
   wire        wr_fire   = awvalid && wvalid && !bvalid_reg;
   wire [31:0] wmask     = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire        wr_ctrla  = wr_fire && (awaddr == OFS_CTRLA);
   wire        wr_ctrlb  = wr_fire && (awaddr == OFS_CTRLB);
   wire        wr_evctrl = wr_fire && (awaddr == OFS_EVCTRL);
   wire        wr_inten  = wr_fire && (awaddr == OFS_INTEN);
   wire        wr_flag   = wr_fire && (awaddr == OFS_INTFLAG);
   wire        wr_count  = wr_fire && (awaddr == OFS_COUNT);
   wire        wr_period = wr_fire && (awaddr == OFS_PERIOD);
   wire        wr_ctrlc  = wr_fire && (awaddr == OFS_CTRLC);
   wire        wr_pcount = wr_fire && (awaddr == OFS_PART_COUNT);
   wire        wr_known  = wr_ctrla || wr_ctrlb || wr_evctrl || wr_inten || wr_flag || wr_count ||
                           wr_period || wr_ctrlc || wr_pcount ||
                           (wr_fire && (awaddr == OFS_CC0 || awaddr == OFS_CC1 ||
                                        awaddr == OFS_STATUS || awaddr == OFS_PART_STATUS));
   // Read channel decode
   wire        rd_fire   = arvalid && !rvalid_reg;
   // Width mask and top value
   wire        paired    = (width_reg == WIDTH_THIRTYTWO);
   wire [31:0] wmax      = (width_reg == WIDTH_EIGHT) ? MAX8 : paired ? MAX32 : MAX16;
   wire        cc_top    = (wave_reg == CHANNEL_TOP_TOGGLE_MODE) || (wave_reg == CHANNEL_TOP_PULSE_MODE);
   wire [31:0] top_val   = cc_top ? (cc_reg[0] & wmax) :
                           (width_reg == WIDTH_EIGHT) ? {24'h000000, period_reg} : wmax;
   wire [31:0] merged    = (count_reg & ~wmask) | (wdata & wmask);
   wire [31:0] count_wv  = merged & wmax;
   // Tick stream: events bypass the prescaled clock when counting events
   wire        tick      = (evact_reg == EVACT_COUNT) ? event_in : gclk_tick;
   wire        ev_rst    = event_in && (evact_reg == RESTART_ACTION);
   wire        ev_start  = event_in && (evact_reg == EVACT_START);
   wire        cmd_retr  = (cmd_reg == CMD_RESTART_ACTION);
   wire        cmd_stop  = (cmd_reg == CMD_STOP);
   wire        is_run    = (state_reg == ST_RUN);
   // Start conditions from each idle state
   wire        go_off    = (state_reg == ST_OFF) && enable_reg &&
                           (evact_reg != RESTART_ACTION) && (evact_reg != EVACT_START);
   wire        go_armed  = (state_reg == ST_ARMED) && (cmd_retr || ev_rst || ev_start);
   wire        go_halt   = (state_reg == ST_HALT) && (cmd_retr || ev_rst || ev_start);
   wire        start_any = go_off || go_armed || go_halt;
   wire        stop_run  = is_run && cmd_stop;
   wire        retr_run  = is_run && (cmd_retr || ev_rst) && !cmd_stop;
   wire        tick_run  = is_run && tick && !cmd_stop && !retr_run;
   wire        at_end    = dir_reg ? (count_reg == 32'h00000000) : (count_reg == top_val);
   wire        wrap      = tick_run && at_end;
   wire [31:0] load_val  = dir_reg ? top_val : 32'h00000000;
   // Count next value; a bus write has the last word
   always_comb begin
      count_next = count_reg;
      if (start_any && fresh_reg) begin
         count_next = load_val;
      end else if (retr_run) begin
         count_next = load_val;
      end else if (wrap) begin
         count_next = dir_reg ? top_val : 32'h00000000;
      end else if (tick_run) begin
         count_next = dir_reg ? ((count_reg - 32'h00000001) & wmax)
                              : ((count_reg + 32'h00000001) & wmax);
      end
      if (wr_count) begin
         count_next = count_wv;
      end
   end
   // Counter state transitions
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (go_off) state_next = ST_RUN;
            else if (enable_reg) state_next = ST_ARMED;
         end
         ST_ARMED: begin
            if (go_armed) state_next = ST_RUN;
         end
         ST_RUN: begin
            if (stop_run || (wrap && oneshot_reg)) state_next = ST_HALT;
         end
         ST_HALT: begin
            if (go_halt) state_next = ST_RUN;
         end
         default: state_next = ST_OFF;
      endcase
      if (!enable_reg) state_next = ST_OFF;
   end
   // State, count and freshness; disabling re-arms the start load, a count write cancels it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_OFF;
         count_reg <= 32'h00000000;
         fresh_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         fresh_reg <= !wr_count && ((wr_ctrla && !wdata[CTRLA_ENABLE]) || (fresh_reg && !start_any));
      end
   end
   // Control registers written over the bus
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         width_reg   <= WIDTH_SIXTEEN;
         wave_reg    <= PLAIN_TOGGLE_MODE;
         enable_reg  <= 1'b0;
         dir_reg     <= 1'b0;
         oneshot_reg <= 1'b0;
         cmd_reg     <= CMD_NONE;
         evact_reg   <= EVACT_OFF;
         ovfeo_reg   <= 1'b0;
         mceo_reg    <= '0;
         ovf_ie_reg  <= 1'b0;
         mc_ie_reg   <= '0;
         inv_reg     <= '0;
         period_reg  <= PERIOD_RESET;
      end else begin
         // Command runs in the cycle after the write, then clears
         cmd_reg <= wr_ctrlb ? wdata[CTRLB_CMD_LSB +: 2] : CMD_NONE;
         if (wr_ctrla) begin
            width_reg  <= wdata[CTRLA_WIDTH_LSB +: 2];
            wave_reg   <= wdata[CTRLA_WAVE_LSB +: 2];
            enable_reg <= wdata[CTRLA_ENABLE];
         end
         if (wr_ctrlb) begin
            dir_reg     <= wdata[COUNT_DIRECTION_BIT];
            oneshot_reg <= wdata[CTRLB_ONESHOT];
         end
         if (wr_evctrl) begin
            evact_reg <= wdata[2:0];
            ovfeo_reg <= wdata[OVERFLOW_EVENT_OUT_ENABLE];
            mceo_reg  <= wdata[EVCTRL_MCEO_LSB +: NUM_CH];
         end
         if (wr_inten) begin
            ovf_ie_reg <= wdata[FLAG_OVF];
            mc_ie_reg  <= wdata[FLAG_MC_LSB +: NUM_CH];
         end
         if (wr_ctrlc) inv_reg <= wdata[NUM_CH-1:0];
         if (wr_period) period_reg <= wdata[7:0];
      end
   end
   // Overflow flag and event: set wins over write-one-to-clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovf_flag_reg <= 1'b0;
         ovf_event    <= 1'b0;
      end else begin
         ovf_flag_reg <= wrap || (ovf_flag_reg && !(wr_flag && wdata[FLAG_OVF]));
         ovf_event    <= wrap && ovfeo_reg;
      end
   end

   // Compare channels
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         wire cc_wr = wr_fire && (awaddr == (OFS_CC0 + 8'(4 * ch)));
         wire hit   = tick_run && (count_reg == (cc_reg[ch] & wmax));
         // Compare value, flag, event and waveform state
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               cc_reg[ch]       <= 32'h00000000;
               mc_flag_reg[ch]  <= 1'b0;
               match_event[ch]  <= 1'b0;
               wave_out_reg[ch] <= 1'b0;
            end else begin
               if (cc_wr) cc_reg[ch] <= (cc_reg[ch] & ~wmask) | (wdata & wmask);
               mc_flag_reg[ch] <= hit || (mc_flag_reg[ch] && !(wr_flag && wdata[FLAG_MC_LSB + ch]));
               match_event[ch] <= hit && mceo_reg[ch];
               if (stop_run || !enable_reg || (state_next == ST_HALT)) begin
                  wave_out_reg[ch] <= 1'b0;
               end else if (hit && (wave_reg == PLAIN_TOGGLE_MODE)) begin
                  wave_out_reg[ch] <= !wave_out_reg[ch];
               end
            end
         end
      end
   endgenerate

   // Pin outputs and interrupt
   assign waveform_out = wave_out_reg ^ inv_reg;
   assign irq = (ovf_flag_reg && ovf_ie_reg) || |(mc_flag_reg & mc_ie_reg);

   // Odd partner count: frozen while the pair forms one counter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         part_count_reg <= 32'h00000000;
      end else if (wr_pcount && !paired) begin
         part_count_reg <= ((part_count_reg & ~wmask) | (wdata & wmask)) & MAX16;
      end
   end

   // Read data selection
   wire [31:0] rd_mux =
      (araddr == OFS_CTRLA)   ? {27'h0, enable_reg, wave_reg, width_reg} :
      (araddr == OFS_CTRLB)   ? {26'h0, cmd_reg, 2'h0, oneshot_reg, dir_reg} :
      (araddr == OFS_EVCTRL)  ? {18'h0, mceo_reg, 3'h0, ovfeo_reg, 5'h0, evact_reg} :
      (araddr == OFS_INTEN)   ? {26'h0, mc_ie_reg, 3'h0, ovf_ie_reg} :
      (araddr == OFS_INTFLAG) ? {26'h0, mc_flag_reg, 3'h0, ovf_flag_reg} :
      (araddr == OFS_STATUS)  ? {31'h0, state_reg == ST_HALT} :
      (araddr == OFS_COUNT)   ? count_reg :
      (araddr == OFS_PERIOD)  ? {24'h0, period_reg} :
      (araddr == OFS_CC0)     ? cc_reg[0] :
      (araddr == OFS_CC1)     ? cc_reg[1] :
      (araddr == OFS_CTRLC)   ? {30'h0, inv_reg} :
      (araddr == OFS_PART_STATUS) ? {30'h0, paired, 1'b0} :
      (araddr == OFS_PART_COUNT)  ? (paired ? 32'h0 : part_count_reg) :
      32'h00000000;
   wire rd_known = (araddr <= OFS_PART_COUNT) && (araddr[1:0] == 2'b00);

   // Bus response registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg  <= RESP_OKAY;
         rdata_reg  <= 32'h00000000;
      end else begin
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_known ? rd_mux : 32'h00000000;
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Bus handshake outputs
   assign awready = wr_fire;
   assign wready  = wr_fire;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = rd_fire;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_cmd_self_clear: assert property (wr_ctrlb |=> ##1 cmd_reg == CMD_NONE)
      else $error("command field did not return to idle");
   a_stop_freeze: assert property (stop_run && !wr_count |=>
                                   state_reg == ST_HALT && count_reg == $past(count_reg) &&
                                   wave_out_reg == '0)
      else $error("stop command did not freeze and clear outputs");
   a_up_wrap_zero: assert property (wrap && !dir_reg && !wr_count |=>
                                    count_reg == 32'h0 && ovf_flag_reg)
      else $error("up count did not wrap to zero with overflow");
   a_down_wrap_top: assert property (wrap && dir_reg && !wr_count |=> count_reg == $past(top_val))
      else $error("down count did not reload top");
   a_oneshot_halt: assert property (wrap && oneshot_reg && enable_reg |=> state_reg == ST_HALT)
      else $error("one-shot did not halt after wrap");
   a_write_wins: assert property (wr_count |=> count_reg == $past(count_wv))
      else $error("bus write lost to counter update");
   a_ovf_event_out: assert property (wrap && ovfeo_reg |=>
                                     ovf_event ##1 (!ovf_event || $past(wrap && ovfeo_reg)))
      else $error("overflow event missing");
   a_restart_waits: assert property ((state_reg == ST_OFF) && enable_reg &&
                                     evact_reg == RESTART_ACTION |=> state_reg == ST_ARMED)
      else $error("restart action started on enable");
   a_toggle_match: assert property (g_ch[0].hit && wave_reg == PLAIN_TOGGLE_MODE && is_run &&
                                    state_next == ST_RUN |=> wave_out_reg[0] != $past(wave_out_reg[0]))
      else $error("channel 0 did not toggle on match");
   a_slave_isolate: assert property (paired && wr_pcount |=> $stable(part_count_reg))
      else $error("partner count changed while paired");

   c_overflow: cover property (wrap && !dir_reg);
   c_oneshot: cover property (wrap && oneshot_reg ##1 state_reg == ST_HALT);
   c_restart_action: cover property (retr_run);
   c_match_toggle: cover property (g_ch[1].hit && wave_reg == PLAIN_TOGGLE_MODE);
endmodule // event_timer_counter_compare
`default_nettype wire

// ===== sim/tc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module tc_far_end (
   // Clock
   input  wire logic       mclk,
   // Events from the timer
   input  wire logic       ovf_event,
   input  wire logic [1:0] match_event,
   // Ticks and events into the timer
   output logic            gclk_tick,
   output logic            event_in
);
   int ovf_seen   = 0;                 // Overflow events taken in
   int match_seen = 0;                 // Channel 0 match events taken in
   initial gclk_tick = 1'b0;
   initial event_in = 1'b0;
   // Event network tallies one-cycle event pulses
   always @(posedge mclk) begin
      if (ovf_event === 1'b1) ovf_seen <= ovf_seen + 1;
      if (match_event[0] === 1'b1) match_seen <= match_seen + 1;
   end
   // Send n one-cycle pulses, clock ticks or events, three idle cycles apart
   task pulse(input bit ev, input int n);
      repeat (n) begin
         @(posedge mclk);
         if (ev) event_in <= 1'b1;
         else gclk_tick <= 1'b1;
         @(posedge mclk);
         event_in <= 1'b0;
         gclk_tick <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask
endmodule // tc_far_end
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tc_pkg::*;
   logic mclk = 1'b0, rst = 1'b1;            // Clock and reset
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, cap_d;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready, bvalid, rvalid;
   logic [1:0] bresp, rresp, cap_r, match_event, waveform_out;
   logic gclk_tick, event_in, ovf_event, irq;
   int miscompares = 0, total_checks = 0;    // Tallies
   initial forever #5 mclk = ~mclk;
   event_timer_counter_compare i_event_timer_counter_compare (.mclk(mclk), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .gclk_tick(gclk_tick),
      .event_in(event_in), .ovf_event(ovf_event), .match_event(match_event), .irq(irq),
      .waveform_out(waveform_out));
   tc_far_end i_tc_far_end (.mclk(mclk), .ovf_event(ovf_event), .match_event(match_event),
      .gclk_tick(gclk_tick), .event_in(event_in));
   // Print counts and verdict, then end the run
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare a value with its expectation
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Wait, bounded, for a ready or valid; 0 aw, 1 b, 2 ar, 3 r; ends on the taking edge
   task hs(input int w);
      int n;
      logic s;
      n = 0;
      do begin
         @(negedge mclk);
         s = (w == 0) ? awready : (w == 1) ? bvalid : (w == 2) ? arready : rvalid;
         cap_d = rdata;
         cap_r = (w == 1) ? bresp : rresp;
         n++;
      end while (s !== 1'b1 && n < 100);
      if (s !== 1'b1) begin
         miscompares++;
         stop_test();
      end
      @(posedge mclk);
   endtask
   // Register write with expected response
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      hs(0);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      hs(1);
      chk({30'h0, cap_r}, {30'h0, er});
   endtask
   // Register read with expected word and response
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      hs(2);
      arvalid <= 1'b0;
      hs(3);
      chk(cap_d, exp);
      chk({30'h0, cap_r}, {30'h0, er});
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(OFS_CTRLA, 32'h0);
      rd(OFS_PERIOD, 32'hff);
      // Eight-bit up count, period 4, channel 0 compare 2, channel 1 inverted
      wr(OFS_PERIOD, 32'h4);
      wr(OFS_CC0, 32'h2);
      wr(OFS_EVCTRL, 32'h1100);
      wr(OFS_INTEN, 32'h1);
      wr(OFS_CTRLC, 32'h2);
      wr(OFS_CTRLA, 32'h11);
      chk({30'h0, waveform_out}, 32'h2);
      i_tc_far_end.pulse(1'b0, 6);
      rd(OFS_COUNT, 32'h1);
      rd(OFS_INTFLAG, 32'h31);
      chk({31'h0, irq}, 32'h1);
      chk({30'h0, waveform_out}, 32'h3);
      chk(i_tc_far_end.match_seen, 32'h1);
      wr(OFS_CTRLB, 32'h20);
      rd(OFS_CTRLB, 32'h0);
      rd(OFS_STATUS, 32'h1);
      chk({30'h0, waveform_out}, 32'h2);
      i_tc_far_end.pulse(1'b0, 2);
      rd(OFS_COUNT, 32'h1);
      wr(OFS_CTRLB, 32'h10);
      i_tc_far_end.pulse(1'b0, 1);
      rd(OFS_COUNT, 32'h2);
      wr(OFS_INTFLAG, 32'h31);
      chk({31'h0, irq}, 32'h0);
      $display("test up count done");
      // Down count, one-shot, from a written start value
      wr(OFS_CTRLA, 32'h0);
      wr(OFS_COUNT, 32'h2);
      wr(OFS_CTRLB, 32'h3);
      wr(OFS_CTRLA, 32'h11);
      i_tc_far_end.pulse(1'b0, 4);
      rd(OFS_COUNT, 32'h4);
      rd(OFS_STATUS, 32'h1);
      chk(i_tc_far_end.ovf_seen, 32'h2);
      $display("test down one-shot done");
      // Event count action; clock ticks ignored
      wr(OFS_CTRLA, 32'h0);
      wr(OFS_EVCTRL, {29'h0, EVACT_COUNT});
      wr(OFS_CTRLB, 32'h0);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRLA, 32'h11);
      i_tc_far_end.pulse(1'b0, 2);
      i_tc_far_end.pulse(1'b1, 3);
      rd(OFS_COUNT, 32'h3);
      // Restart action: enable arms, event starts from zero
      wr(OFS_CTRLA, 32'h0);
      wr(OFS_EVCTRL, {29'h0, RESTART_ACTION});
      wr(OFS_CTRLA, 32'h11);
      i_tc_far_end.pulse(1'b0, 2);
      rd(OFS_COUNT, 32'h3);
      i_tc_far_end.pulse(1'b1, 1);
      i_tc_far_end.pulse(1'b0, 2);
      rd(OFS_COUNT, 32'h2);
      i_tc_far_end.pulse(1'b1, 1);
      i_tc_far_end.pulse(1'b0, 1);
      rd(OFS_COUNT, 32'h1);
      // Start action, channel 0 as top: enable arms, event starts, later event ignored
      wr(OFS_CTRLA, 32'h0);
      wr(OFS_EVCTRL, {29'h0, EVACT_START});
      wr(OFS_CTRLA, 32'h15);
      i_tc_far_end.pulse(1'b0, 1);
      rd(OFS_COUNT, 32'h1);
      i_tc_far_end.pulse(1'b1, 1);
      i_tc_far_end.pulse(1'b0, 1);
      i_tc_far_end.pulse(1'b1, 1);
      i_tc_far_end.pulse(1'b0, 2);
      rd(OFS_COUNT, 32'h0);
      $display("test event actions done");
      // Paired width: partner shows slave bit and ignores writes
      wr(OFS_CTRLA, 32'h0);
      wr(OFS_PART_COUNT, 32'h5);
      rd(OFS_PART_COUNT, 32'h5);
      rd(OFS_PART_STATUS, 32'h0);
      wr(OFS_CTRLA, {30'h0, WIDTH_THIRTYTWO});
      rd(OFS_PART_STATUS, 32'h2);
      wr(OFS_PART_COUNT, 32'h7);
      rd(OFS_PART_COUNT, 32'h0);
      wr(OFS_CTRLA, 32'h0);
      rd(OFS_PART_COUNT, 32'h5);
      wr(8'hfc, 32'h1, RESP_SLVERR);
      rd(8'hfc, 32'h0, RESP_SLVERR);
      $display("test pairing done");
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
